// ==== shared/urbs_pkg.sv ====
// constants and types of the serial receive buffer and status block
//
// Operation
// - ninth bit and error flags stored per entry
// - receive complete reads one while data unread
// - clearing receiver enable flushes the buffer
// - interrupt request held while enabled and unread
// - error flags describe next readable character
// - status writes never change error flags
// - error flags raise no interrupt
// - frame error is inverted first stop bit
// - only first stop bit is checked
// - overrun on full buffer, waiting frame, start
// - overrun clears on successful buffer transfer
// - parity checked only when enabled, odd/even select
// - parity error valid for next readable character
// - parity error reads zero when checking disabled; here an entry received with checking on keeps its pe flag after disabling
// - disabling the receiver stops reception at once
// - sixteen samples per bit, eight double speed
// - realign on each start bit, filter bits
// - start bit vote at samples 8-10 or 4-6
// - each bit decided by two-of-three vote
// - unused upper data bits read zero
// - receiver enable takes over receive pin
package urbs_pkg;
	// register offsets
	localparam logic [1:0] OFS_STATUS = 2'h0;
	localparam logic [1:0] OFS_CONTROL = 2'h1;
	localparam logic [1:0] OFS_FORMAT = 2'h2;
	localparam logic [1:0] OFS_DATA = 2'h3;
	// status bits
	localparam int ST_RXC_BIT = 7;
	localparam int ST_FE_BIT = 4;
	localparam int ST_DOR_BIT = 3;
	localparam int ST_UPE_BIT = 2;
	localparam int ST_U2X_BIT = 1;
	// control bits
	localparam int CT_RX_COMPLETE_IRQ_ENABLE_BIT = 7;
	localparam int CT_RECEIVER_ENABLE_BIT = 4;
	localparam int CT_SIZE2_BIT = 2;
	localparam int CT_RX9_BIT = 1;
	localparam int CT_TX9_BIT = 0;
	// format bits
	localparam int FM_PAR_EN_BIT = 5;
	localparam int FM_PAR_ODD_BIT = 4;
	localparam int FM_STOP_BIT = 3;
	localparam int FM_SIZE_LSB = 1;
	// reset value and nine-bit size code
	localparam logic [1:0] SIZE_LOW_RST = 2'h3;
	localparam logic [2:0] SIZE_NINE = 3'h7;
	// sample indices (sample number minus one)
	localparam logic [3:0] N_VOTE_LAST = 4'h9;
	localparam logic [3:0] N_BIT_LAST = 4'hF;
	localparam logic [3:0] D_VOTE_LAST = 4'h5;
	localparam logic [3:0] D_BIT_LAST = 4'h7;

	typedef struct packed {
		logic [8:0] data;
		logic fe;
		logic overrun_flag;
		logic pe;
	} urbs_entry_type;

	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS, ST_STOP} urbs_state_type;
endpackage

// ==== verilog/urbs_receiver.sv ====
// serial receiver with two-entry receive buffer and status registers
`timescale 1ns/100ps
`default_nettype none
module urbs_receiver #(
	parameter int FIFO_DEPTH = 2
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// register port
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// serial side
	input wire logic sample_tick,
	input wire logic rxd_pin,
	output logic rxd_override,
	// request
	output logic rx_irq
);
	localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(FIFO_DEPTH);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic rx_meta_r, rx_sync_r, rx_last_r;
	logic rx_complete_irq_enable_r, receiver_enable_r, size2_r, tx9_r, u2x_r;
	logic par_en_r, par_odd_r, stop_sel_r;
	logic [1:0] size_low_r;
	logic [7:0] reg_rdata_r;
	urbs_pkg::urbs_state_type state_r;
	logic [3:0] cnt_r, bitidx_r;
	logic [1:0] vote_r;
	logic [8:0] sh_data_r;
	logic sh_acc_r, sh_pbit_r, sh_fe_r, sh_pe_r;
	logic hold_r, lost_r;
	urbs_pkg::urbs_entry_type mem_r [FIFO_DEPTH];
	logic [PW-1:0] wr_ptr_r, rd_ptr_r;
	logic [CW-1:0] count_r;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire logic [2:0] size_code = {size2_r, size_low_r};
	wire logic [3:0] nbits = (size_code == urbs_pkg::SIZE_NINE) ? 4'h9 :
		(size_code[2] ? 4'h8 : 4'h5 + {2'h0, size_code[1:0]});
	wire logic [3:0] nlast = nbits - {3'h0, ~par_en_r};
	wire logic [3:0] vote_last = u2x_r ? urbs_pkg::D_VOTE_LAST :
		urbs_pkg::N_VOTE_LAST;
	wire logic [3:0] bit_last = u2x_r ? urbs_pkg::D_BIT_LAST :
		urbs_pkg::N_BIT_LAST;
	wire logic at_vote = sample_tick && (cnt_r == vote_last);
	wire logic at_end = sample_tick && (cnt_r == bit_last);
	wire logic maj = (vote_r[1] & vote_r[0]) | (vote_r[1] & rx_sync_r) |
		(vote_r[0] & rx_sync_r);
	wire logic fall = sample_tick && rx_last_r && !rx_sync_r;
	wire logic start_ok = (state_r == urbs_pkg::ST_START) && at_vote && !maj;
	wire logic frame_done = (state_r == urbs_pkg::ST_STOP) && at_vote;
	wire logic empty = (count_r == '0);
	wire logic sel_status = reg_addr == urbs_pkg::OFS_STATUS;
	wire logic sel_control = reg_addr == urbs_pkg::OFS_CONTROL;
	wire logic sel_format = reg_addr == urbs_pkg::OFS_FORMAT;
	wire logic sel_data = reg_addr == urbs_pkg::OFS_DATA;
	wire logic pop = reg_rd && sel_data && !empty;
	wire logic push = hold_r && receiver_enable_r && ((count_r != CNT_FULL) || pop);
	wire logic overrun = start_ok && hold_r && !push;
	wire logic par_bad = par_en_r && (sh_acc_r ^ sh_pbit_r ^ par_odd_r);
	urbs_pkg::urbs_entry_type head, in_entry;
	assign head = empty ? '0 : mem_r[rd_ptr_r];
	assign in_entry = '{data: sh_data_r, fe: sh_fe_r, overrun_flag: lost_r,
		pe: sh_pe_r};

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	wire logic [7:0] status_rd = (8'h01 << urbs_pkg::ST_RXC_BIT) & {8{!empty}}
		| (8'h01 << urbs_pkg::ST_FE_BIT) & {8{head.fe}}
		| (8'h01 << urbs_pkg::ST_DOR_BIT) & {8{head.overrun_flag}}
		| (8'h01 << urbs_pkg::ST_UPE_BIT) & {8{head.pe}}
		| (8'h01 << urbs_pkg::ST_U2X_BIT) & {8{u2x_r}};
	wire logic [7:0] control_rd = (8'h01 << urbs_pkg::CT_RX_COMPLETE_IRQ_ENABLE_BIT) & {8{rx_complete_irq_enable_r}}
		| (8'h01 << urbs_pkg::CT_RECEIVER_ENABLE_BIT) & {8{receiver_enable_r}}
		| (8'h01 << urbs_pkg::CT_SIZE2_BIT) & {8{size2_r}}
		| (8'h01 << urbs_pkg::CT_RX9_BIT) & {8{head.data[8]}}
		| (8'h01 << urbs_pkg::CT_TX9_BIT) & {8{tx9_r}};
	wire logic [7:0] format_rd = (8'h01 << urbs_pkg::FM_PAR_EN_BIT) & {8{par_en_r}}
		| (8'h01 << urbs_pkg::FM_PAR_ODD_BIT) & {8{par_odd_r}}
		| (8'h01 << urbs_pkg::FM_STOP_BIT) & {8{stop_sel_r}}
		| {5'h00, size_low_r, 1'b0};
	wire logic [7:0] rdata_nxt = !reg_rd ? 8'h00 :
		sel_status ? status_rd : sel_control ? control_rd :
		sel_format ? format_rd : head.data[7:0];

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reg_rdata_r <= 8'h00;
		end else begin
			reg_rdata_r <= rdata_nxt;
		end
	end

	// status write only reaches the speed bit; flags live in the fifo
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			u2x_r <= 1'b0;
			rx_complete_irq_enable_r <= 1'b0;
			receiver_enable_r <= 1'b0;
			size2_r <= 1'b0;
			tx9_r <= 1'b0;
			par_en_r <= 1'b0;
			par_odd_r <= 1'b0;
			stop_sel_r <= 1'b0;
			size_low_r <= urbs_pkg::SIZE_LOW_RST;
		end else if (reg_wr) begin
			if (sel_status) begin
				u2x_r <= reg_wdata[urbs_pkg::ST_U2X_BIT];
			end
			if (sel_control) begin
				rx_complete_irq_enable_r <= reg_wdata[urbs_pkg::CT_RX_COMPLETE_IRQ_ENABLE_BIT];
				receiver_enable_r <= reg_wdata[urbs_pkg::CT_RECEIVER_ENABLE_BIT];
				size2_r <= reg_wdata[urbs_pkg::CT_SIZE2_BIT];
				tx9_r <= reg_wdata[urbs_pkg::CT_TX9_BIT];
			end
			if (sel_format) begin
				par_en_r <= reg_wdata[urbs_pkg::FM_PAR_EN_BIT];
				par_odd_r <= reg_wdata[urbs_pkg::FM_PAR_ODD_BIT];
				stop_sel_r <= reg_wdata[urbs_pkg::FM_STOP_BIT];
				size_low_r <= reg_wdata[urbs_pkg::FM_SIZE_LSB +: 2];
			end
		end
	end

	assign reg_rdata = reg_rdata_r;
	assign rxd_override = receiver_enable_r;
	assign rx_irq = rx_complete_irq_enable_r && !empty;

	// ----------------------------------------------------------------
	// pin synchroniser and sampling
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rx_meta_r <= 1'b1;
			rx_sync_r <= 1'b1;
			rx_last_r <= 1'b1;
			vote_r <= 2'h3;
		end else begin
			rx_meta_r <= rxd_pin;
			rx_sync_r <= rx_meta_r;
			if (sample_tick) begin
				rx_last_r <= rx_sync_r;
				vote_r <= {vote_r[0], rx_sync_r};
			end
		end
	end

	// ----------------------------------------------------------------
	// frame recovery
	// ----------------------------------------------------------------
	// a disabled receiver drops any frame at once, no drain
	always_ff @(posedge ref_clk) begin
		if (reset || !receiver_enable_r) begin
			state_r <= urbs_pkg::ST_IDLE;
			cnt_r <= 4'h0;
			bitidx_r <= 4'h0;
		end else begin
			unique case (state_r)
				urbs_pkg::ST_IDLE: begin
					if (fall) begin
						state_r <= urbs_pkg::ST_START;
						cnt_r <= 4'h1;
					end
				end
				urbs_pkg::ST_START: begin
					if (at_vote && maj) begin
						state_r <= urbs_pkg::ST_IDLE;
						cnt_r <= 4'h0;
					end else if (at_end) begin
						state_r <= urbs_pkg::ST_BITS;
						cnt_r <= 4'h0;
						bitidx_r <= 4'h0;
					end else if (sample_tick) begin
						cnt_r <= cnt_r + 4'h1;
					end
				end
				urbs_pkg::ST_BITS: begin
					if (at_end) begin
						cnt_r <= 4'h0;
						if (bitidx_r == nlast) begin
							state_r <= urbs_pkg::ST_STOP;
						end else begin
							bitidx_r <= bitidx_r + 4'h1;
						end
					end else if (sample_tick) begin
						cnt_r <= cnt_r + 4'h1;
					end
				end
				urbs_pkg::ST_STOP: begin
					// back to idle after the vote: early start allowed
					if (at_vote) begin
						state_r <= urbs_pkg::ST_IDLE;
						cnt_r <= 4'h0;
					end else if (sample_tick) begin
						cnt_r <= cnt_r + 4'h1;
					end
				end
			endcase
		end
	end

	// shift register; the start state already holds the old frame
	always_ff @(posedge ref_clk) begin
		if (reset || !receiver_enable_r) begin
			sh_data_r <= 9'h000;
			sh_acc_r <= 1'b0;
			sh_pbit_r <= 1'b0;
			sh_fe_r <= 1'b0;
			sh_pe_r <= 1'b0;
		end else if (state_r == urbs_pkg::ST_START && at_end) begin
			sh_data_r <= 9'h000;
			sh_acc_r <= 1'b0;
		end else if (state_r == urbs_pkg::ST_BITS && at_vote) begin
			if (bitidx_r < nbits) begin
				sh_data_r[bitidx_r] <= maj;
				sh_acc_r <= sh_acc_r ^ maj;
			end else begin
				sh_pbit_r <= maj;
			end
		end else if (frame_done) begin
			sh_fe_r <= !maj;
			sh_pe_r <= par_bad;
		end
	end

	// hold marks a complete frame waiting for a free entry
	always_ff @(posedge ref_clk) begin
		if (reset || !receiver_enable_r) begin
			hold_r <= 1'b0;
			lost_r <= 1'b0;
		end else begin
			if (frame_done) begin
				hold_r <= 1'b1;
			end else if (push || overrun) begin
				hold_r <= 1'b0;
			end
			if (overrun) begin
				lost_r <= 1'b1;
			end else if (push) begin
				lost_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// receive buffer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_entry;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || !receiver_enable_r) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= PW'((int'(wr_ptr_r) + 1) % FIFO_DEPTH);
			end
			if (pop) begin
				rd_ptr_r <= PW'((int'(rd_ptr_r) + 1) % FIFO_DEPTH);
			end
			if (push && !pop) begin
				count_r <= count_r + CW'(1);
			end else if (pop && !push) begin
				count_r <= count_r - CW'(1);
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	property p_flush;
		!receiver_enable_r |=> empty && !rx_irq;
	endproperty
	a_flush: assert property (p_flush)
		else $error("buffer not flushed when receiver disabled");

	property p_pop_last;
		pop && count_r == CW'(1) && !push |=> empty && !rx_irq &&
			!status_rd[urbs_pkg::ST_RXC_BIT];
	endproperty
	a_pop_last: assert property (p_pop_last)
		else $error("complete flag stays after last read");

	property p_irq;
		rx_complete_irq_enable_r && receiver_enable_r && !empty && !pop && !(reg_wr && sel_control)
			|=> rx_irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("receive request dropped with data unread");

	property p_stop_now;
		!receiver_enable_r |-> !rxd_override ##1
			(state_r == urbs_pkg::ST_IDLE && !hold_r);
	endproperty
	a_stop_now: assert property (p_stop_now)
		else $error("reception not abandoned at once");

	property p_flags_kept;
		reg_wr && sel_status && !pop && !push && !empty |=>
			$stable({head.fe, head.overrun_flag, head.pe});
	endproperty
	a_flags_kept: assert property (p_flags_kept)
		else $error("status write altered error flags");

	property p_fe;
		frame_done |=> sh_fe_r == !$past(maj);
	endproperty
	a_fe: assert property (p_fe)
		else $error("frame error does not follow stop bit");

	property p_no_par;
		frame_done && !par_en_r |=> !sh_pe_r;
	endproperty
	a_no_par: assert property (p_no_par)
		else $error("parity error with checking disabled");

	property p_overrun;
		overrun |=> lost_r && !hold_r;
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun not recorded");

	property p_dor_clear;
		push |=> !lost_r && mem_r[$past(wr_ptr_r)].overrun_flag == $past(lost_r);
	endproperty
	a_dor_clear: assert property (p_dor_clear)
		else $error("overrun not cleared on transfer");

	property p_pop_count;
		pop && !push |=> count_r == $past(count_r) - CW'(1);
	endproperty
	a_pop_count: assert property (p_pop_count)
		else $error("data read did not advance buffer");

	property p_reject;
		state_r == urbs_pkg::ST_START && at_vote && maj |=>
			state_r == urbs_pkg::ST_IDLE;
	endproperty
	a_reject: assert property (p_reject)
		else $error("noisy start bit accepted");

	c_frame: cover property (push ##[1:40] pop);
	c_overrun: cover property (overrun);
	c_parity: cover property (push && in_entry.pe);
	c_flush: cover property (!empty ##1 !receiver_enable_r);
endmodule // urbs_receiver
`default_nettype wire

// ==== verif/urbs_line_tx.sv ====
// remote serial transmitter model driving the receive line
`timescale 1ns/100ps
`default_nettype none
module urbs_line_tx (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// frame request
	input wire logic sample_tick,
	input wire logic go,
	input wire logic [11:0] bits,
	input wire logic [3:0] nbits,
	input wire logic [4:0] spb,
	// line
	output logic rxd,
	output logic busy
);
	logic [11:0] sh_r;
	logic [3:0] idx_r;
	logic [4:0] cnt_r;
	// -----------------------------
	// bit timing
	// -----------------------------
	// line rests high between frames, the idle mark level
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rxd <= 1'b1;
			busy <= 1'b0;
		end else if (go && !busy) begin
			busy <= 1'b1;
			sh_r <= bits;
			idx_r <= 4'h0;
			cnt_r <= 5'h00;
			rxd <= bits[0];
		end else if (busy && sample_tick) begin
			if (cnt_r == spb - 5'h01) begin
				cnt_r <= 5'h00;
				idx_r <= idx_r + 4'h1;
				if (idx_r == nbits - 4'h1) begin
					busy <= 1'b0;
					rxd <= 1'b1;
				end else begin
					rxd <= sh_r[idx_r + 4'h1];
				end
			end else begin
				cnt_r <= cnt_r + 5'h01;
			end
		end
	end
endmodule // urbs_line_tx
`default_nettype wire

// ==== verif/tb_urbs_receiver.sv ====
// self-checking bench of the serial receive buffer block
`timescale 1ns/100ps
`default_nettype none
module tb_urbs_receiver;
	logic ref_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0;
	logic sample_tick = 0, go = 0, rxd, rxd_override, rx_irq, busy;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, s;
	logic [11:0] bits = 12'h000;
	logic [3:0] nbits = 4'h1;
	logic [4:0] spb = 5'h10;
	int mismatches = 0, total_checks = 0, cyc = 0, tdiv = 0;
	int q[$];
	int hold = -1;
	int lost = 0, ie = 0, dbl = 0;
	urbs_receiver dut (.ref_clk(ref_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_tick(sample_tick),
		.rxd_pin(rxd), .rxd_override(rxd_override), .rx_irq(rx_irq));
	urbs_line_tx far (.ref_clk(ref_clk), .reset(reset),
		.sample_tick(sample_tick), .go(go), .bits(bits), .nbits(nbits),
		.spb(spb), .rxd(rxd), .busy(busy));
	// -----------------------------
	// clock, sample ticks, timeout
	// -----------------------------
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		tdiv <= (tdiv == 2) ? 0 : tdiv + 1;
		sample_tick <= (tdiv == 2);
		cyc = cyc + 1;
		if (cyc > 60000) begin
			mismatches = mismatches + 1;
			end_sim();
		end
	end
	// -----------------------------
	// tasks
	// -----------------------------
	task automatic end_sim();
		if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input int e, input logic [8:0] g);
		total_checks++;
		if (g !== 9'(e)) begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#10 v = reg_rdata;
	endtask
	// software setup; bits 7 irq enable, 4 enable, 2 ninth size
	task automatic cfg(input int nb, par, odd, en, sb);
		logic [1:0] lo;
		lo = (nb == 9) ? 2'h3 : 2'(nb - 5);
		ie = en;
		wr(urbs_pkg::OFS_CONTROL, {1'(en), 2'h0, 1'b1, 1'b0, nb == 9, 2'h0});
		wr(urbs_pkg::OFS_FORMAT, {2'h0, 1'(par), 1'(odd), 1'(sb), lo, 1'b0});
		wr(urbs_pkg::OFS_STATUS, {6'h00, 1'(dbl), 1'b0});
	endtask
	// reference buffer: two entries plus one waiting frame
	task automatic send(input int d, nb, par, odd, flip, stv, sp);
		logic [11:0] b;
		int n, e, i;
		b = 12'(d << 1);
		n = 1 + nb;
		if (par) begin
			b[n] = (^d[8:0]) ^ odd[0] ^ flip[0];
			n++;
		end
		b[n] = stv[0];
		n++;
		if (q.size() == 2 && hold >= 0) begin
			hold = -1;
			lost = 1;
		end
		@(posedge ref_clk);
		bits <= b;
		nbits <= 4'(n);
		spb <= 5'(sp);
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		i = 0;
		do begin
			@(negedge ref_clk);
			i++;
		end while (busy === 1'b1 && i < 3000);
		if (busy === 1'b1) begin
			mismatches++;
			end_sim();
		end
		repeat (6) @(posedge ref_clk);
		e = d | ((1 - stv) << 9) | ((par & flip) << 11);
		if (q.size() < 2) begin
			q.push_back(e | (lost << 10));
			lost = 0;
		end else hold = e;
	endtask
	// software order: status, then control ninth bit, then data
	task automatic pop();
		logic [7:0] c, d;
		int e;
		e = q[0];
		chk("irq", ie, rx_irq);
		chk("override", 1, rxd_override);
		rd(urbs_pkg::OFS_STATUS, s);
		rd(urbs_pkg::OFS_CONTROL, c);
		rd(urbs_pkg::OFS_DATA, d);
		chk("rxc", 1, s[urbs_pkg::ST_RXC_BIT]);
		chk("fe", (e >> 9) & 1, s[urbs_pkg::ST_FE_BIT]);
		chk("dor", (e >> 10) & 1, s[urbs_pkg::ST_DOR_BIT]);
		chk("pe", (e >> 11) & 1, s[urbs_pkg::ST_UPE_BIT]);
		chk("ninth", (e >> 8) & 1, c[urbs_pkg::CT_RX9_BIT]);
		chk("data", e & 255, d);
		void'(q.pop_front());
		if (hold >= 0) begin
			q.push_back(hold | (lost << 10));
			hold = -1;
			lost = 0;
		end
	endtask
	// -----------------------------
	// scenarios
	// -----------------------------
	initial begin
		void'($urandom(32'h055F));
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		rd(urbs_pkg::OFS_STATUS, s);
		chk("st_rst", 0, s);
		rd(urbs_pkg::OFS_FORMAT, s);
		chk("fmt_rst", 6, s);
		rd(urbs_pkg::OFS_DATA, s);
		chk("empty_rd", 0, s);
		chk("irq_rst", 0, rx_irq);
		for (int nb = 5; nb <= 9; nb++) begin
			cfg(nb, 0, 0, 1, 0);
			repeat (2) send($urandom & ((1 << nb) - 1), nb, 0, 0, 0, 1, 16);
			repeat (2) pop();
			rd(urbs_pkg::OFS_STATUS, s);
			chk("rxc_empty", 0, s[urbs_pkg::ST_RXC_BIT]);
		end
		for (int k = 0; k < 4; k++) begin
			cfg(8, 1, k & 1, 1, 0);
			send($urandom & 255, 8, 1, k & 1, k >> 1, 1, 16);
			pop();
		end
		cfg(8, 0, 0, 0, 1);
		send($urandom & 255, 8, 0, 0, 0, 0, 16);
		wr(urbs_pkg::OFS_STATUS, 8'h00);
		pop();
		dbl = 1;
		cfg(8, 0, 0, 1, 0);
		send($urandom & 255, 8, 0, 0, 0, 1, 8);
		pop();
		dbl = 0;
		cfg(8, 0, 0, 1, 0);
		// short low glitch of three samples must be rejected
		@(posedge ref_clk);
		bits <= 12'h000;
		nbits <= 4'h1;
		spb <= 5'h03;
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		repeat (300) @(posedge ref_clk);
		rd(urbs_pkg::OFS_STATUS, s);
		chk("noise", 0, s[urbs_pkg::ST_RXC_BIT]);
		repeat (4) send($urandom & 255, 8, 0, 0, 0, 1, 16);
		repeat (3) pop();
		send($urandom & 255, 8, 0, 0, 0, 1, 16);
		pop();
		repeat (2) send($urandom & 255, 8, 0, 0, 0, 1, 16);
		wr(urbs_pkg::OFS_CONTROL, 8'h80);
		rd(urbs_pkg::OFS_STATUS, s);
		chk("flush", 0, s[urbs_pkg::ST_RXC_BIT]);
		chk("irq_off", 0, rx_irq);
		chk("pin_free", 0, rxd_override);
		rd(urbs_pkg::OFS_DATA, s);
		chk("flush_rd", 0, s);
		end_sim();
	end
endmodule // tb_urbs_receiver
`default_nettype wire
